// file: include/pcs_pkg.sv
// Summary of operation
// - Bank 0 register 106 bit 0 switches the first PLL on when one and off when zero, and resets to zero.
// - Bank 0 register 108 holds the eight-bit first PLL feedback divider and resets to zero.
// - Bank 0 register 110 bit 0 enables the second PLL when one and resets to zero.
// - Bank 0 register 112 holds the eight-bit second PLL feedback divider and resets to zero.
// - The reference input divider is held in reset while bank 0 register 114 bit 0 is zero, its reset value.
// - Read-only bank 0 register 115 shows first PLL lock in bit 0 and second PLL lock in bit 1, one meaning locked.
// - Bank 0 register 116 reads a fixed eight-bit revision number and ignores writes.
// - Bank 0 register 117 bit 0 at zero keeps the shutter lag and at one removes it.
// - Bank 0 register 118 bit 0 at zero selects monochrome column grouping and at one paired colour grouping.
// - Bank 1 register 5 holds the eight-bit shutter timing granularity and resets to one.
// - Bank 1 register 6 bits 2:1 set output clock phase 0, 90, 180 or 270 degrees and reset to code 1.
// - Bank 1 register 6 resets reserved bit 3 to one and reserved bits 0 and 6:4 to zero.
package pcs_pkg;
  localparam logic [6:0] PCS_ADDR_PLL_A_ON        = 7'h6A;
  localparam logic [6:0] PCS_ADDR_PLL_A_IN_RANGE  = 7'h6B;
  localparam logic [6:0] PCS_ADDR_PLL_A_FB_DIV    = 7'h6C;
  localparam logic [6:0] PCS_ADDR_PLL_A_OUT_RANGE = 7'h6D;
  localparam logic [6:0] PCS_ADDR_PLL_B_ON        = 7'h6E;
  localparam logic [6:0] PCS_ADDR_PLL_B_FB_DIV    = 7'h70;
  localparam logic [6:0] PCS_ADDR_REF_DIV_RELEASE = 7'h72;
  localparam logic [6:0] PCS_ADDR_LOCK_STATUS     = 7'h73;
  localparam logic [6:0] PCS_ADDR_REVISION        = 7'h74;
  localparam logic [6:0] PCS_ADDR_SHUTTER_NO_LAG  = 7'h75;
  localparam logic [6:0] PCS_ADDR_COLUMN_PAIRING  = 7'h76;
  localparam logic [6:0] PCS_ADDR_SHUTTER_STEP    = 7'h05;
  localparam logic [6:0] PCS_ADDR_OUT_CLK_CFG     = 7'h06;

  localparam logic       PCS_BANK_0 = 1'b0;
  localparam logic       PCS_BANK_1 = 1'b1;

  localparam int         PCS_LOCK_A_BIT   = 0;
  localparam int         PCS_LOCK_B_BIT   = 1;
  localparam int         PCS_PHASE_LSB    = 1;
  localparam int         PCS_PHASE_MSB    = 2;

  localparam logic [7:0] PCS_RST_ZERO         = 8'h00;
  localparam logic [7:0] PCS_RST_SHUTTER_STEP = 8'h01;
  // Phase code 1 in bits 2:1, reserved bit 3 set, bits 0 and 6:4 clear.
  localparam logic [6:0] PCS_RST_OUT_CLK_CFG  = 7'h0A;
  // Revision value is arbitrary.
  localparam logic [7:0] PCS_REVISION_VALUE   = 8'h5C;
endpackage

// file: design/pcs_lock_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for the asynchronous PLL lock levels.
module pcs_lock_sync (
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_en_in,
  input  wire logic [1:0] lock_raw_in,
  output var  logic [1:0] lock_sync_out
);
  logic [1:0] meta_q;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      meta_q        <= 2'h0;
      lock_sync_out <= 2'h0;
    end else if (clk_en_in) begin
      meta_q        <= lock_raw_in;
      lock_sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: design/pcs_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_config_regs (
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_en_in,
  input  wire logic       wr_en_in,
  input  wire logic       rd_en_in,
  input  wire logic       bank_in,
  input  wire logic [6:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       pll_a_locked_in,
  input  wire logic       pll_b_locked_in,
  output var  logic [7:0] rdata_out,
  output var  logic       rdata_valid_out,
  output var  logic       pll_a_on_out,
  output var  logic [1:0] pll_a_input_range_out,
  output var  logic [7:0] pll_a_feedback_divider_out,
  output var  logic [1:0] pll_a_output_range_out,
  output var  logic       pll_b_on_out,
  output var  logic [7:0] pll_b_feedback_divider_out,
  output var  logic       ref_divider_reset_n_out,
  output var  logic       shutter_lag_enable_out,
  output var  logic       double_exposure_column_pairing_out,
  output var  logic [7:0] shutter_timing_step_out,
  output var  logic [1:0] output_clock_phase_out,
  output var  logic [6:0] output_clock_generator_config_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic       b0;
  logic [1:0] lock_sync;
  logic [7:0] rd_mux;

  assign b0 = (bank_in == pcs_pkg::PCS_BANK_0);

  pcs_lock_sync u_lock_sync (
    .sys_clk_in    (sys_clk_in),
    .nrst_in       (nrst_in),
    .clk_en_in     (clk_en_in),
    .lock_raw_in   ({pll_b_locked_in, pll_a_locked_in}),
    .lock_sync_out (lock_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write decode: one hit line per writable register.

  // Slot order fixes the index of each hit line below.
  localparam int NUM_WR          = 11;
  localparam int HIT_A_ON        = 0;
  localparam int HIT_A_IN_RANGE  = 1;
  localparam int HIT_A_FB_DIV    = 2;
  localparam int HIT_A_OUT_RANGE = 3;
  localparam int HIT_B_ON        = 4;
  localparam int HIT_B_FB_DIV    = 5;
  localparam int HIT_REF_DIV     = 6;
  localparam int HIT_NO_LAG      = 7;
  localparam int HIT_PAIRING     = 8;
  localparam int HIT_STEP        = 9;
  localparam int HIT_CFG         = 10;

  // Status and revision have no slot, so writes to them fall through unseen.
  localparam logic [7:0] WR_SLOT [NUM_WR] = '{
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_PLL_A_ON},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_PLL_A_IN_RANGE},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_PLL_A_FB_DIV},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_PLL_A_OUT_RANGE},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_PLL_B_ON},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_PLL_B_FB_DIV},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_REF_DIV_RELEASE},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_SHUTTER_NO_LAG},
    {pcs_pkg::PCS_BANK_0, pcs_pkg::PCS_ADDR_COLUMN_PAIRING},
    {pcs_pkg::PCS_BANK_1, pcs_pkg::PCS_ADDR_SHUTTER_STEP},
    {pcs_pkg::PCS_BANK_1, pcs_pkg::PCS_ADDR_OUT_CLK_CFG}
  };

  logic              wr_take;
  logic [NUM_WR-1:0] wr_hit;

  // A write only counts while the clock enable lets the bank advance.
  assign wr_take = clk_en_in && wr_en_in;

  for (genvar k = 0; k < NUM_WR; k++) begin : g_wr_hit
    assign wr_hit[k] = wr_take && ({bank_in, addr_in} == WR_SLOT[k]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // First PLL controls.

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pll_a_on_out <= pcs_pkg::PCS_RST_ZERO[0];
    end else if (wr_hit[HIT_A_ON]) begin
      pll_a_on_out <= wdata_in[0];
    end
  end

  // Range codes are stored as written; picking the right one is up to software.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pll_a_input_range_out <= pcs_pkg::PCS_RST_ZERO[1:0];
    end else if (wr_hit[HIT_A_IN_RANGE]) begin
      pll_a_input_range_out <= wdata_in[1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pll_a_feedback_divider_out <= pcs_pkg::PCS_RST_ZERO;
    end else if (wr_hit[HIT_A_FB_DIV]) begin
      pll_a_feedback_divider_out <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pll_a_output_range_out <= pcs_pkg::PCS_RST_ZERO[1:0];
    end else if (wr_hit[HIT_A_OUT_RANGE]) begin
      pll_a_output_range_out <= wdata_in[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second PLL controls and reference divider reset.

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pll_b_on_out <= pcs_pkg::PCS_RST_ZERO[0];
    end else if (wr_hit[HIT_B_ON]) begin
      pll_b_on_out <= wdata_in[0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pll_b_feedback_divider_out <= pcs_pkg::PCS_RST_ZERO;
    end else if (wr_hit[HIT_B_FB_DIV]) begin
      pll_b_feedback_divider_out <= wdata_in;
    end
  end

  // Held low from reset so the divider never runs before software is ready.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      ref_divider_reset_n_out <= pcs_pkg::PCS_RST_ZERO[0];
    end else if (wr_hit[HIT_REF_DIV]) begin
      ref_divider_reset_n_out <= wdata_in[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutter, exposure and output clock controls.

  // The output is an enable, so it is the inverse of the stored bit.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      shutter_lag_enable_out <= ~pcs_pkg::PCS_RST_ZERO[0];
    end else if (wr_hit[HIT_NO_LAG]) begin
      shutter_lag_enable_out <= ~wdata_in[0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      double_exposure_column_pairing_out <= pcs_pkg::PCS_RST_ZERO[0];
    end else if (wr_hit[HIT_PAIRING]) begin
      double_exposure_column_pairing_out <= wdata_in[0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      shutter_timing_step_out <= pcs_pkg::PCS_RST_SHUTTER_STEP;
    end else if (wr_hit[HIT_STEP]) begin
      shutter_timing_step_out <= wdata_in;
    end
  end

  // Reserved bits are stored as written so software can restore them.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      output_clock_generator_config_out <= pcs_pkg::PCS_RST_OUT_CLK_CFG;
    end else if (wr_hit[HIT_CFG]) begin
      output_clock_generator_config_out <= wdata_in[6:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      output_clock_phase_out <= pcs_pkg::PCS_RST_OUT_CLK_CFG[pcs_pkg::PCS_PHASE_MSB:pcs_pkg::PCS_PHASE_LSB];
    end else if (wr_hit[HIT_CFG]) begin
      output_clock_phase_out <= wdata_in[pcs_pkg::PCS_PHASE_MSB:pcs_pkg::PCS_PHASE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle after the read strobe, unmapped reads return zero.

  always_comb begin
    rd_mux = 8'h00;
    if (b0) begin
      unique case (addr_in)
        pcs_pkg::PCS_ADDR_PLL_A_ON:        rd_mux = {7'h00, pll_a_on_out};
        pcs_pkg::PCS_ADDR_PLL_A_IN_RANGE:  rd_mux = {6'h00, pll_a_input_range_out};
        pcs_pkg::PCS_ADDR_PLL_A_FB_DIV:    rd_mux = pll_a_feedback_divider_out;
        pcs_pkg::PCS_ADDR_PLL_A_OUT_RANGE: rd_mux = {6'h00, pll_a_output_range_out};
        pcs_pkg::PCS_ADDR_PLL_B_ON:        rd_mux = {7'h00, pll_b_on_out};
        pcs_pkg::PCS_ADDR_PLL_B_FB_DIV:    rd_mux = pll_b_feedback_divider_out;
        pcs_pkg::PCS_ADDR_REF_DIV_RELEASE: rd_mux = {7'h00, ref_divider_reset_n_out};
        pcs_pkg::PCS_ADDR_LOCK_STATUS:     rd_mux = {6'h00, lock_sync[pcs_pkg::PCS_LOCK_B_BIT],
                                                     lock_sync[pcs_pkg::PCS_LOCK_A_BIT]};
        pcs_pkg::PCS_ADDR_REVISION:        rd_mux = pcs_pkg::PCS_REVISION_VALUE;
        pcs_pkg::PCS_ADDR_SHUTTER_NO_LAG:  rd_mux = {7'h00, ~shutter_lag_enable_out};
        pcs_pkg::PCS_ADDR_COLUMN_PAIRING:  rd_mux = {7'h00, double_exposure_column_pairing_out};
        default:                           rd_mux = 8'h00;
      endcase
    end else begin
      unique case (addr_in)
        pcs_pkg::PCS_ADDR_SHUTTER_STEP:    rd_mux = shutter_timing_step_out;
        pcs_pkg::PCS_ADDR_OUT_CLK_CFG:     rd_mux = {1'b0, output_clock_generator_config_out};
        default:                           rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rdata_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      rdata_valid_out <= rd_en_in;
    end
  end

  // Read data holds between reads, so a slow master may pick it up late.
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (clk_en_in && rd_en_in) begin
      rdata_out <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// file: testbench/pcs_config_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_config_regs_checker (
  input wire logic       sys_clk_in,
  input wire logic       nrst_in,
  input wire logic       clk_en_in,
  input wire logic       wr_en_in,
  input wire logic       rd_en_in,
  input wire logic       bank_in,
  input wire logic [6:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic       rdata_valid_out,
  input wire logic       pll_a_on_out,
  input wire logic [7:0] pll_a_feedback_divider_out,
  input wire logic [7:0] pll_b_feedback_divider_out,
  input wire logic       ref_divider_reset_n_out,
  input wire logic       shutter_lag_enable_out,
  input wire logic [1:0] output_clock_phase_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);
  //////////////////////////////////////////////////////////////////////////////
  // A request only counts when the clock enable lets the bank see it.
  sequence wr_at(logic b, logic [6:0] a);
    clk_en_in && wr_en_in && bank_in == b && addr_in == a;
  endsequence
  sequence rd_at(logic b, logic [6:0] a);
    clk_en_in && rd_en_in && bank_in == b && addr_in == a;
  endsequence
  chk_a_on_write: assert property (
    wr_at(1'b0, pcs_pkg::PCS_ADDR_PLL_A_ON) |=> pll_a_on_out == $past(wdata_in[0]))
    else $error("pll a enable did not follow write");
  chk_a_fb_write: assert property (
    wr_at(1'b0, pcs_pkg::PCS_ADDR_PLL_A_FB_DIV) |=> pll_a_feedback_divider_out == $past(wdata_in))
    else $error("pll a divider did not follow write");
  chk_b_fb_write: assert property (
    wr_at(1'b0, pcs_pkg::PCS_ADDR_PLL_B_FB_DIV) |=> pll_b_feedback_divider_out == $past(wdata_in))
    else $error("pll b divider did not follow write");
  chk_ref_release: assert property (
    wr_at(1'b0, pcs_pkg::PCS_ADDR_REF_DIV_RELEASE) |=> ref_divider_reset_n_out == $past(wdata_in[0]))
    else $error("reference divider reset did not follow write");
  chk_lag_inverse: assert property (
    wr_at(1'b0, pcs_pkg::PCS_ADDR_SHUTTER_NO_LAG) |=> shutter_lag_enable_out == !$past(wdata_in[0]))
    else $error("shutter lag output not inverse of written bit");
  chk_phase_write: assert property (
    wr_at(1'b1, pcs_pkg::PCS_ADDR_OUT_CLK_CFG) |=> output_clock_phase_out == $past(wdata_in[2:1]))
    else $error("clock phase did not follow write");
  chk_lock_read: assert property (
    rd_at(1'b0, pcs_pkg::PCS_ADDR_LOCK_STATUS) |=> rdata_valid_out && rdata_out[7:2] == 6'h00)
    else $error("lock status read malformed");
  chk_revision_read: assert property (
    rd_at(1'b0, pcs_pkg::PCS_ADDR_REVISION) |=> rdata_valid_out && rdata_out == pcs_pkg::PCS_REVISION_VALUE)
    else $error("revision read wrong");
endmodule
bind pcs_config_regs pcs_config_regs_checker pcs_config_regs_checker_i (
  .sys_clk_in, .nrst_in, .clk_en_in, .wr_en_in, .rd_en_in, .bank_in, .addr_in, .wdata_in, .rdata_out,
  .rdata_valid_out, .pll_a_on_out, .pll_a_feedback_divider_out, .pll_b_feedback_divider_out,
  .ref_divider_reset_n_out, .shutter_lag_enable_out, .output_clock_phase_out
);
`default_nettype wire

// file: testbench/pcs_config_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pcs_config_regs_tb_top;
  logic        sys_clk_in = 1'b0, nrst_in = 1'b0, clk_en_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
  logic        bank_in = 1'b0, pll_a_locked_in = 1'b0, pll_b_locked_in = 1'b0;
  logic [6:0]  addr_in = 7'h00, output_clock_generator_config_out;
  logic [7:0]  wdata_in = 8'h00, rdata_out, pll_a_feedback_divider_out, pll_b_feedback_divider_out;
  logic [7:0]  shutter_timing_step_out;
  logic        rdata_valid_out, pll_a_on_out, pll_b_on_out, ref_divider_reset_n_out;
  logic        shutter_lag_enable_out, double_exposure_column_pairing_out;
  logic [1:0]  pll_a_input_range_out, pll_a_output_range_out, output_clock_phase_out;
  logic [41:0] outs;
  int          fail_count = 0;
  int          comparisons = 0;
  // Bit 7 of each entry selects bank 1; 0x71 is unmapped.
  localparam logic [7:0] REG_AT [14] = '{8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h70, 8'h72, 8'h73, 8'h74, 8'h75,
                                         8'h76, 8'h85, 8'h86, 8'h71};
  localparam logic [7:0] REG_RST [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5C,
                                          8'h00, 8'h00, 8'h01, 8'h0A, 8'h00};
  localparam logic [7:0] REG_WR [14] = '{8'h01, 8'h03, 8'hA5, 8'h02, 8'h01, 8'h5A, 8'h01, 8'h03, 8'hFF,
                                         8'h01, 8'h01, 8'hC3, 8'h0C, 8'hFF};
  localparam logic [7:0] REG_RB [14] = '{8'h01, 8'h03, 8'hA5, 8'h02, 8'h01, 8'h5A, 8'h01, 8'h00, 8'h5C,
                                         8'h01, 8'h01, 8'hC3, 8'h0C, 8'h00};
  localparam logic [41:0] OUT_RST = {1'b0, 2'h0, 8'h00, 2'h0, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0, 8'h01, 2'h1, 7'h0A};
  localparam logic [41:0] OUT_WR = {1'b1, 2'h3, 8'hA5, 2'h2, 1'b1, 8'h5A, 1'b1, 1'b0, 1'b1, 8'hC3, 2'h2, 7'h0C};
  always #4 sys_clk_in = ~sys_clk_in;
  assign outs = {pll_a_on_out, pll_a_input_range_out, pll_a_feedback_divider_out, pll_a_output_range_out,
                 pll_b_on_out, pll_b_feedback_divider_out, ref_divider_reset_n_out, shutter_lag_enable_out,
                 double_exposure_column_pairing_out, shutter_timing_step_out, output_clock_phase_out,
                 output_clock_generator_config_out};
  pcs_config_regs pcs_config_regs_i (.sys_clk_in, .nrst_in, .clk_en_in, .wr_en_in, .rd_en_in, .bank_in, .addr_in,
    .wdata_in, .pll_a_locked_in, .pll_b_locked_in, .rdata_out, .rdata_valid_out, .pll_a_on_out,
    .pll_a_input_range_out, .pll_a_feedback_divider_out, .pll_a_output_range_out, .pll_b_on_out,
    .pll_b_feedback_divider_out, .ref_divider_reset_n_out, .shutter_lag_enable_out,
    .double_exposure_column_pairing_out, .shutter_timing_step_out, .output_clock_phase_out,
    .output_clock_generator_config_out);
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(string what, logic [41:0] exp, logic [41:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Outputs are sampled on the falling edge so the write edge has landed.
  task automatic wr_reg(logic [7:0] ba, logic [7:0] d);
    @(posedge sys_clk_in);
    {wr_en_in, bank_in, addr_in, wdata_in} <= {1'b1, ba, d};
    @(posedge sys_clk_in);
    wr_en_in <= 1'b0;
    @(negedge sys_clk_in);
  endtask
  task automatic rd_chk(logic [7:0] ba, logic [7:0] exp);
    @(posedge sys_clk_in);
    {rd_en_in, bank_in, addr_in} <= {1'b1, ba};
    @(posedge sys_clk_in);
    rd_en_in <= 1'b0;
    @(negedge sys_clk_in);
    cmp($sformatf("read %h", ba), {33'h0, 1'b1, exp}, {33'h0, rdata_valid_out, rdata_out});
  endtask
  task automatic test_reset();
    nrst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(negedge sys_clk_in);
    cmp("reset outputs", OUT_RST, outs);
    for (int i = 0; i < 14; i++) rd_chk(REG_AT[i], REG_RST[i]);
    $display("test reset done");
  endtask
  task automatic test_write_all();
    for (int i = 0; i < 14; i++) wr_reg(REG_AT[i], REG_WR[i]);
    cmp("written outputs", OUT_WR, outs);
    for (int i = 0; i < 14; i++) rd_chk(REG_AT[i], REG_RB[i]);
    $display("test write all done");
  endtask
  task automatic test_codes();
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h6B, 8'(i));
      wr_reg(8'h86, 8'(8 + 2 * i));
      if (i < 3) wr_reg(8'h6D, 8'(i));
      cmp("codes", {36'h0, 2'(i), (i < 3) ? 2'(i) : 2'h2, 2'(i)},
          {36'h0, pll_a_input_range_out, pll_a_output_range_out, output_clock_phase_out});
    end
    $display("test codes done");
  endtask
  // A frozen clock enable must swallow the write entirely.
  task automatic test_clk_en();
    @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    wr_reg(8'h6C, 8'h11);
    cmp("frozen divider", 42'hA5, {34'h0, pll_a_feedback_divider_out});
    @(posedge sys_clk_in);
    clk_en_in <= 1'b1;
    $display("test clock enable done");
  endtask
  task automatic test_lock();
    for (int i = 1; i < 4; i++) begin
      @(posedge sys_clk_in);
      {pll_b_locked_in, pll_a_locked_in} <= 2'(i);
      repeat (3) @(posedge sys_clk_in);
      rd_chk(8'h73, 8'(i));
    end
    $display("test lock done");
  endtask
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    test_reset();
    test_write_all();
    test_codes();
    test_clk_en();
    test_reset();
    test_lock();
    test_done();
  end
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
